// >>> hw/sbsc_core.sv
/*
 Bus state code and own address block of a two-wire serial controller.
 Holds the control word, own slave address, clock-rate preset and the
 8-bit state code, and runs the bus engine that produces the codes.
 Assumes an APB master, pins with open-drain pads built outside.
*/
`timescale 1ns/1ps
module sbsc_core
   import sbsc_pkg::*;
#(
   parameter int FREE_MULT = 10
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_oe,
   output logic sda_oe
);

   initial
   begin
      if (FREE_MULT < 1 || FREE_MULT > 15)
         $error("FREE_MULT out of range");
   end

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_DATA = 7'h04,
      ST_ACK = 7'h08,
      ST_HOLD = 7'h10,
      ST_STOP = 7'h20,
      ST_START = 7'h40
   } sbsc_state_t;

   sbsc_pins_t pins;
   sbsc_events_t ev;
   sbsc_state_t state;
   logic [7:0] control;
   logic [7:0] own_slave_address;
   logic [7:0] clock_rate_preset;
   logic [7:0] bus_state_code;
   logic [7:0] shift_data_register;
   logic [7:0] rate_cnt;
   logic [3:0] free_cnt;
   logic [3:0] bit_cnt;
   logic master;
   logic transmit;
   logic gcall;
   logic busy;
   logic first_byte;
   logic last_nack;
   logic scl_tick;
   logic [7:0] next_code;
   logic next_raise;
   logic wr;
   logic rd;
   logic sda_sent;

   sbsc_line_watch u_watch
   (
      .pclk(pclk),
      .presetn(presetn),
      .pins_async({scl_in, sda_in}),
      .pins(pins),
      .events(ev)
   );

   // ==========================================================
   // APB slave, zero wait states
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (rd && !penable)
         begin
            case (paddr[SBSC_ADDR_W-1:0])
               SBSC_ADDR_CONTROL:
                  prdata <= {24'h000000, busy, control[6:0]};
               SBSC_ADDR_STATE:
                  prdata <= {24'h000000, bus_state_code};
               SBSC_ADDR_OWN_ADDR:
                  prdata <= {24'h000000, own_slave_address};
               SBSC_ADDR_RATE:
                  prdata <= {24'h000000, clock_rate_preset};
               default:
                  pslverr <= 1'b1;
            endcase
         end
         else if (psel && !penable && paddr[SBSC_ADDR_W-1:0] != SBSC_ADDR_CONTROL
                  && paddr[SBSC_ADDR_W-1:0] != SBSC_ADDR_STATE
                  && paddr[SBSC_ADDR_W-1:0] != SBSC_ADDR_OWN_ADDR
                  && paddr[SBSC_ADDR_W-1:0] != SBSC_ADDR_RATE)
            pslverr <= 1'b1;
      end
   end

   // ==========================================================
   // Address and rate registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         own_slave_address <= SBSC_RST_OWN_ADDR;
         clock_rate_preset <= SBSC_RST_RATE;
      end
      else if (wr && pready)
      begin
         if (paddr[SBSC_ADDR_W-1:0] == SBSC_ADDR_OWN_ADDR)
            own_slave_address <= pwdata[7:0];
         if (paddr[SBSC_ADDR_W-1:0] == SBSC_ADDR_RATE)
            clock_rate_preset <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Control word; hardware sets the flag, software clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         control <= 8'h00;
      else
      begin
         if (wr && pready && paddr[SBSC_ADDR_W-1:0] == SBSC_ADDR_CONTROL)
            control <= {1'b0, pwdata[6:0]};
         if (next_raise)
            control[SBSC_CTL_IRQ] <= 1'b1;
         if (ev.stop || (state == ST_STOP && scl_tick))
            control[SBSC_CTL_STOP] <= 1'b0;
         if (state == ST_START && scl_tick)
            control[SBSC_CTL_START] <= 1'b0;
      end
   end

   // ==========================================================
   // State code register
   // state writes are dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_state_code <= SBSC_RST_STATE;
      else if (next_raise)
         bus_state_code <= {next_code[7:3], 3'h0};
      else if (state == ST_IDLE && !control[SBSC_CTL_IRQ])
         bus_state_code <= SC_IDLE;
   end

   // ==========================================================
   // Rate divider and SCL-high free timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate_cnt <= 8'h00;
         free_cnt <= 4'h0;
         scl_tick <= 1'b0;
      end
      else
      begin
         scl_tick <= 1'b0;
         if (!pins.scl || state == ST_IDLE && !control[SBSC_CTL_FREE])
         begin
            rate_cnt <= clock_rate_preset;
            free_cnt <= 4'h0;
         end
         else if (rate_cnt == 8'hff)
         begin
            rate_cnt <= clock_rate_preset;
            scl_tick <= 1'b1;
            free_cnt <= (free_cnt == FREE_MULT[3:0]) ? free_cnt : free_cnt + 4'h1;
         end
         else
            rate_cnt <= rate_cnt + 8'h01;
      end
   end

   // ==========================================================
   // Bus engine and its events
   assign sda_sent = transmit ? shift_data_register[7] : 1'b1;

   always_comb
   begin
      next_code = SC_IDLE;
      next_raise = 1'b0;
      if (ev.start && busy && state != ST_ADDR && state != ST_IDLE)
      begin
         next_raise = 1'b1;
         if (!master)
            next_code = SC_SR_STOP;
         else if (state != ST_START)
            next_code = SC_BUS_ERROR;
      end
      else if ((ev.stop || (control[SBSC_CTL_STOP] && !master)) && busy && state != ST_IDLE)
      begin
         next_raise = 1'b1;
         if (!master)
            next_code = SC_SR_STOP;
         else
            next_code = SC_BUS_ERROR;
      end
      else if (state == ST_START && scl_tick)
      begin
         next_raise = 1'b1;
         // start or repeated start
         // Own START makes the bus busy, so only a held master means repeated
         next_code = master ? SC_RSTART : SC_START;
      end
      else if (control[SBSC_CTL_FREE] && free_cnt == FREE_MULT[3:0] - 4'h1 && scl_tick && busy)
      begin
         next_raise = 1'b1;
         next_code = SC_TIMEOUT;
      end
      // Slave address phase was already reported at the compare
      else if (state == ST_ACK && ev.bit_rise && (master || !first_byte))
      begin
         next_raise = 1'b1;
         if (master && first_byte)
            next_code = transmit ? (pins.sda ? SC_MT_SLA_NACK : SC_MT_SLA_ACK)
                                 : (pins.sda ? SC_MR_SLA_NACK : SC_MR_SLA_ACK);
         else if (master && transmit)
            next_code = pins.sda ? SC_MT_DAT_NACK : SC_MT_DAT_ACK;
         else if (master)
            next_code = control[SBSC_CTL_ACK] ? SC_MR_DAT_ACK : SC_MR_DAT_NACK;
         else if (transmit)
            next_code = pins.sda ? SC_ST_DAT_NACK : (last_nack ? SC_ST_LAST_ACK : SC_ST_DAT_ACK);
         else if (gcall)
            next_code = control[SBSC_CTL_ACK] ? SC_SR_GC_DAT_ACK : SC_SR_GC_DAT_NACK;
         else
            next_code = control[SBSC_CTL_ACK] ? SC_SR_DAT_ACK : SC_SR_DAT_NACK;
      end
      else if (state == ST_ADDR && bit_cnt == 4'h8 && control[SBSC_CTL_ACK])
      begin
         if (shift_data_register[7:1] == own_slave_address[7:1])
         begin
            next_raise = 1'b1;
            if (shift_data_register[0])
               next_code = master ? SC_ST_ARB_SLA : SC_ST_SLA_ACK;
            else
               next_code = master ? SC_SR_ARB_SLA : SC_SR_SLA_ACK;
         end
         else if (shift_data_register == SBSC_ADDR_GENERAL && own_slave_address[SBSC_GC_BIT])
         begin
            next_raise = 1'b1;
            next_code = master ? SC_SR_ARB_GC : SC_SR_GC_ACK;
         end
      end
      else if (master && transmit && ev.bit_rise && sda_sent && !pins.sda
               && (state == ST_DATA || state == ST_ADDR) && !first_byte)
      begin
         next_raise = 1'b1;
         next_code = SC_ARB_LOST;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         shift_data_register <= 8'h00;
         bit_cnt <= 4'h0;
         master <= 1'b0;
         transmit <= 1'b0;
         gcall <= 1'b0;
         busy <= 1'b0;
         first_byte <= 1'b0;
         last_nack <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         if (ev.start)
            busy <= 1'b1;
         if (ev.stop)
            busy <= 1'b0;
         if (next_raise && (next_code == SC_SR_STOP || next_code == SC_BUS_ERROR
                            || next_code == SC_TIMEOUT))
         begin
            state <= ST_IDLE;
            master <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  if (control[SBSC_CTL_EN] && control[SBSC_CTL_START] && !busy)
                     state <= ST_START;
                  else if (ev.start)
                  begin
                     state <= ST_ADDR;
                     bit_cnt <= 4'h0;
                     first_byte <= 1'b0;
                  end
               end
               ST_START:
               begin
                  sda_oe <= 1'b1;
                  if (scl_tick)
                  begin
                     master <= 1'b1;
                     first_byte <= 1'b1;
                     transmit <= 1'b1;
                     state <= ST_HOLD;
                  end
               end
               ST_ADDR, ST_DATA:
               begin
                  if (ev.bit_rise)
                  begin
                     shift_data_register <= {shift_data_register[6:0], pins.sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (bit_cnt == 4'h8)
                  begin
                     state <= ST_ACK;
                     if (state == ST_ADDR && next_raise)
                     begin
                        master <= 1'b0;
                        first_byte <= 1'b1;
                        transmit <= shift_data_register[0];
                        gcall <= (shift_data_register == SBSC_ADDR_GENERAL);
                     end
                     else if (state == ST_ADDR && !master)
                        state <= ST_IDLE;
                  end
                  if (next_raise && next_code == SC_ARB_LOST)
                  begin
                     master <= 1'b0;
                     state <= ST_IDLE;
                  end
                  sda_oe <= !sda_sent && transmit;
               end
               ST_ACK:
               begin
                  // Slave acks its own address even when it will transmit
                  sda_oe <= (!transmit || first_byte && !master) && control[SBSC_CTL_ACK];
                  if (ev.bit_rise)
                  begin
                     if (first_byte && master)
                        transmit <= !shift_data_register[0];
                     first_byte <= 1'b0;
                     last_nack <= !control[SBSC_CTL_ACK];
                     // Refused slave transmitter lets go of the bus
                     if (!master && transmit && pins.sda)
                        state <= ST_IDLE;
                     else
                        state <= ST_HOLD;
                  end
               end
               ST_HOLD:
               begin
                  scl_oe <= control[SBSC_CTL_IRQ];
                  if (!control[SBSC_CTL_IRQ])
                  begin
                     bit_cnt <= 4'h0;
                     if (control[SBSC_CTL_STOP] && master)
                        state <= ST_STOP;
                     else if (control[SBSC_CTL_START] && master)
                        state <= ST_START;
                     else
                        state <= ST_DATA;
                  end
               end
               ST_STOP:
               begin
                  sda_oe <= 1'b1;
                  if (scl_tick)
                  begin
                     sda_oe <= 1'b0;
                     master <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// >>> hw/sbsc_line_watch.sv
/*
 Line watcher: synchronises SCL and SDA and reports START, STOP and
 SCL rising edges as one-cycle pulses on pclk.
 Assumes both lines come from pins outside the pclk domain.
*/
`timescale 1ns/1ps
module sbsc_line_watch
   import sbsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire sbsc_pins_t pins_async,
   output sbsc_pins_t pins,
   output sbsc_events_t events
);

   sbsc_pins_t meta;
   sbsc_pins_t prev;

   // ==========================================================
   // Two-stage synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= '1;
         pins <= '1;
         prev <= '1;
      end
      else
      begin
         meta <= pins_async;
         pins <= meta;
         prev <= pins;
      end
   end

   // ==========================================================
   // Condition detection
   always_comb
   begin
      events.start = prev.scl && pins.scl && prev.sda && !pins.sda;
      events.stop = prev.scl && pins.scl && !prev.sda && pins.sda;
      events.bit_rise = !prev.scl && pins.scl;
   end

endmodule

// >>> hw/sbsc_pkg.sv
/*
 Package for the bus state code and own address block: register offsets,
 reset values, field positions, state codes and carrier structs.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package sbsc_pkg;

   // ==========================================================
   // Register map (printed offsets are indices, byte = 4 x index)
   localparam logic [7:0] SBSC_IDX_CONTROL = 8'hc0;
   localparam logic [7:0] SBSC_IDX_STATE = 8'hc1;
   localparam logic [7:0] SBSC_IDX_OWN_ADDR = 8'hc3;
   localparam logic [7:0] SBSC_IDX_RATE = 8'hcf;
   localparam int SBSC_ADDR_W = 12;
   localparam logic [11:0] SBSC_ADDR_CONTROL = {2'h0, SBSC_IDX_CONTROL, 2'h0};
   localparam logic [11:0] SBSC_ADDR_STATE = {2'h0, SBSC_IDX_STATE, 2'h0};
   localparam logic [11:0] SBSC_ADDR_OWN_ADDR = {2'h0, SBSC_IDX_OWN_ADDR, 2'h0};
   localparam logic [11:0] SBSC_ADDR_RATE = {2'h0, SBSC_IDX_RATE, 2'h0};

   // ==========================================================
   // Reset values
   localparam logic [7:0] SBSC_RST_STATE = 8'hf8;
   localparam logic [7:0] SBSC_RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] SBSC_RST_RATE = 8'h00;

   // ==========================================================
   // Control word bit positions
   localparam int SBSC_CTL_START = 5;
   localparam int SBSC_CTL_STOP = 4;
   localparam int SBSC_CTL_IRQ = 3;
   localparam int SBSC_CTL_ACK = 2;
   localparam int SBSC_CTL_FREE = 1;
   localparam int SBSC_CTL_BUSY = 7;
   localparam int SBSC_CTL_EN = 6;
   localparam int SBSC_GC_BIT = 0;

   // ==========================================================
   // State codes
   localparam logic [7:0] SC_BUS_ERROR = 8'h00;
   localparam logic [7:0] SC_START = 8'h08;
   localparam logic [7:0] SC_RSTART = 8'h10;
   localparam logic [7:0] SC_MT_SLA_ACK = 8'h18;
   localparam logic [7:0] SC_MT_SLA_NACK = 8'h20;
   localparam logic [7:0] SC_MT_DAT_ACK = 8'h28;
   localparam logic [7:0] SC_MT_DAT_NACK = 8'h30;
   localparam logic [7:0] SC_ARB_LOST = 8'h38;
   localparam logic [7:0] SC_MR_SLA_ACK = 8'h40;
   localparam logic [7:0] SC_MR_SLA_NACK = 8'h48;
   localparam logic [7:0] SC_MR_DAT_ACK = 8'h50;
   localparam logic [7:0] SC_MR_DAT_NACK = 8'h58;
   localparam logic [7:0] SC_SR_SLA_ACK = 8'h60;
   localparam logic [7:0] SC_SR_ARB_SLA = 8'h68;
   localparam logic [7:0] SC_SR_GC_ACK = 8'h70;
   localparam logic [7:0] SC_SR_ARB_GC = 8'h78;
   localparam logic [7:0] SC_SR_DAT_ACK = 8'h80;
   localparam logic [7:0] SC_SR_DAT_NACK = 8'h88;
   localparam logic [7:0] SC_SR_GC_DAT_ACK = 8'h90;
   localparam logic [7:0] SC_SR_GC_DAT_NACK = 8'h98;
   localparam logic [7:0] SC_SR_STOP = 8'ha0;
   localparam logic [7:0] SC_ST_SLA_ACK = 8'ha8;
   localparam logic [7:0] SC_ST_ARB_SLA = 8'hb0;
   localparam logic [7:0] SC_ST_DAT_ACK = 8'hb8;
   localparam logic [7:0] SC_ST_DAT_NACK = 8'hc0;
   localparam logic [7:0] SC_ST_LAST_ACK = 8'hc8;
   localparam logic [7:0] SC_TIMEOUT = 8'hd0;
   localparam logic [7:0] SC_IDLE = 8'hf8;
   localparam logic [7:0] SBSC_ADDR_GENERAL = 8'h00;

   // ==========================================================
   // Carrier structs
   typedef struct packed {
      logic scl;
      logic sda;
   } sbsc_pins_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic bit_rise;
   } sbsc_events_t;

endpackage

// >>> verification/sbsc_bus_model.sv
/*
 Model of another master on the two-wire bus, lines with pull-ups.
 Assumes its tasks are called just after a pclk edge.
*/
`timescale 1ns/1ps
module sbsc_bus_model
   import sbsc_pkg::*;
(
   input wire logic pclk,
   input wire logic scl_oe,
   input wire logic sda_oe,
   output sbsc_pins_t line
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   // ====
   // Wired-and lines; released lines float high
   assign line = {!(scl_low || scl_oe), !(sda_low || sda_oe)};
   task automatic edges(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // SCL of 80 ns, stands still between frames
   task automatic put_bit(input logic v, output logic got);
      edges(1);
      sda_low <= !v;
      edges(3);
      scl_low <= 1'b0;
      edges(1);
      // Slave may stretch the clock low
      while (line.scl !== 1'b1)
         edges(1);
      edges(3);
      got = line.sda;
      scl_low <= 1'b1;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack_n);
      logic g;
      for (int i = 7; i >= 0; i--)
         put_bit(b[i], g);
      put_bit(1'b1, ack_n);
   endtask
   task automatic start_cond();
      sda_low <= 1'b1;
      edges(4);
      scl_low <= 1'b1;
   endtask
   task automatic stop_cond();
      edges(1);
      sda_low <= 1'b1;
      edges(3);
      scl_low <= 1'b0;
      edges(4);
      sda_low <= 1'b0;
      edges(8);
   endtask
endmodule

// >>> verification/sbsc_chk.sv
/*
 Port checker for the bus state code block.
 Assumes it is bound onto sbsc_core.
*/
`timescale 1ns/1ps
module sbsc_chk
   import sbsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe,
   input wire logic sda_oe
);
   logic [7:0] own;
   logic fresh;
   logic done;
   logic rd;
   logic mapped;
   assign done = psel && penable && pready;
   assign rd = done && !pwrite;
   assign mapped = paddr[11:0] inside {SBSC_ADDR_CONTROL, SBSC_ADDR_STATE, SBSC_ADDR_OWN_ADDR, SBSC_ADDR_RATE};
   // ====
   // Own address shadow, first-transfer marker
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         own <= SBSC_RST_OWN_ADDR;
         fresh <= 1'b1;
      end
      else if (done)
      begin
         fresh <= 1'b0;
         if (pwrite && paddr[11:0] == SBSC_ADDR_OWN_ADDR)
            own <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ====
   // Assertions
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_setup_not_ready: assert property (psel && !penable |-> !pready)
      else $error("ready in setup cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_error: assert property (done && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (done && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_upper_bits_zero: assert property (rd && mapped |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_code_low_zero: assert property (rd && paddr[11:0] == SBSC_ADDR_STATE |-> prdata[2:0] == 3'h0)
      else $error("state code not a multiple of eight");
   a_own_readback: assert property (rd && paddr[11:0] == SBSC_ADDR_OWN_ADDR |-> prdata[7:0] == own)
      else $error("own address readback wrong");
   a_idle_after_reset: assert property (rd && fresh && paddr[11:0] == SBSC_ADDR_STATE |-> prdata[7:0] == SC_IDLE)
      else $error("state not idle after reset");
   a_lines_free_reset: assert property ($rose(presetn) |-> !scl_oe && !sda_oe)
      else $error("line pulled after reset");
   c_state_read: cover property (rd && paddr[11:0] == SBSC_ADDR_STATE);
   c_ack_driven: cover property ($rose(sda_oe));
   c_clock_held: cover property ($rose(scl_oe));
   c_refused: cover property (done && pslverr);
endmodule
bind sbsc_core sbsc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe));

// >>> verification/tb_top.sv
/*
 Self-checking bench for the bus state code block.
 Assumes the bus model and checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top
   import sbsc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic scl_oe;
   logic sda_oe;
   sbsc_pins_t line;
   int miscompares = 0;
   int tests_run = 0;
   always #5 pclk = ~pclk;
   sbsc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(line.scl), .sda_in(line.sda), .scl_oe(scl_oe), .sda_oe(sda_oe));
   sbsc_bus_model u_bus (.pclk(pclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .line(line));
   // ====
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 8'h0, r, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic no_flag();
      logic [31:0] r;
      rd(SBSC_ADDR_CONTROL, r);
      chk({31'h0, r[SBSC_CTL_IRQ]}, 32'h0);
   endtask
   task automatic see_code(input logic [7:0] code, input logic [7:0] ctl);
      logic [31:0] r;
      int n;
      n = 0;
      rd(SBSC_ADDR_CONTROL, r);
      while (r[SBSC_CTL_IRQ] !== 1'b1 && n < 60)
      begin
         rd(SBSC_ADDR_CONTROL, r);
         n++;
      end
      chk({31'h0, r[SBSC_CTL_IRQ]}, 32'h1);
      rd(SBSC_ADDR_STATE, r);
      chk(r, {24'h0, code});
      wr(SBSC_ADDR_CONTROL, ctl);
   endtask
   // ====
   // Scenarios
   task automatic t_reset();
      logic [31:0] r;
      rd(SBSC_ADDR_STATE, r);
      chk(r, {24'h0, SC_IDLE});
      rd(SBSC_ADDR_OWN_ADDR, r);
      chk(r, {24'h0, SBSC_RST_OWN_ADDR});
      no_flag();
      $display("t_reset done");
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      wr(SBSC_ADDR_OWN_ADDR, 8'hb5);
      rd(SBSC_ADDR_OWN_ADDR, r);
      chk(r, 32'hb5);
      wr(SBSC_ADDR_STATE, 8'h00);
      rd(SBSC_ADDR_STATE, r);
      chk(r, {24'h0, SC_IDLE});
      apb(1'b0, 12'h010, 8'h0, r, e);
      chk({31'h0, e}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_slave();
      logic a;
      wr(SBSC_ADDR_CONTROL, 8'h44);
      u_bus.start_cond();
      u_bus.send_byte(8'h34, a);
      chk({31'h0, a}, 32'h1);
      u_bus.stop_cond();
      no_flag();
      u_bus.start_cond();
      u_bus.send_byte(8'hb4, a);
      chk({31'h0, a}, 32'h0);
      see_code(SC_SR_SLA_ACK, 8'h44);
      u_bus.send_byte(8'ha5, a);
      chk({31'h0, a}, 32'h0);
      see_code(SC_SR_DAT_ACK, 8'h44);
      u_bus.stop_cond();
      see_code(SC_SR_STOP, 8'h44);
      u_bus.start_cond();
      u_bus.send_byte(8'hb5, a);
      chk({31'h0, a}, 32'h0);
      see_code(SC_ST_SLA_ACK, 8'h44);
      u_bus.send_byte(8'hff, a);
      see_code(SC_ST_DAT_NACK, 8'h44);
      u_bus.stop_cond();
      wr(SBSC_ADDR_CONTROL, 8'h44);
      $display("t_slave done");
   endtask
   task automatic t_gc();
      logic a;
      u_bus.start_cond();
      u_bus.send_byte(8'h00, a);
      chk({31'h0, a}, 32'h0);
      see_code(SC_SR_GC_ACK, 8'h44);
      u_bus.send_byte(8'h3c, a);
      see_code(SC_SR_GC_DAT_ACK, 8'h40);
      u_bus.send_byte(8'hc3, a);
      chk({31'h0, a}, 32'h1);
      see_code(SC_SR_GC_DAT_NACK, 8'h54);
      see_code(SC_SR_STOP, 8'h44);
      u_bus.stop_cond();
      wr(SBSC_ADDR_CONTROL, 8'h44);
      wr(SBSC_ADDR_OWN_ADDR, 8'hb4);
      u_bus.start_cond();
      u_bus.send_byte(8'h00, a);
      chk({31'h0, a}, 32'h1);
      u_bus.stop_cond();
      no_flag();
      $display("t_gc done");
   endtask
   task automatic t_master();
      logic [31:0] r;
      wr(SBSC_ADDR_RATE, 8'hf0);
      wr(SBSC_ADDR_CONTROL, 8'h60);
      see_code(SC_START, 8'h50);
      repeat (40) @(posedge pclk);
      rd(SBSC_ADDR_CONTROL, r);
      chk(r, 32'h40);
      $display("t_master done");
   endtask
   task automatic close_out();
      $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_slave();
      t_gc();
      t_master();
      close_out();
   end
   initial
   begin
      #300000;
      miscompares++;
      close_out();
   end
endmodule
